// file: qdac_serial_port.sv
// serial command port and code latches of a four-channel dac
//
// Functional notes
// - four wires: select, clock, data in, out
// - every command frame is 32 bits
// - straight binary code, msb at bit 19
// - bits 23:20 pick channel, 1111 all
// - power-up loads the reset code everywhere
// - select input low gives zero-scale startup
// - clear falling edge forces mode-selected code
// - clear code defaults to zero volts
// - in sync mode a write without update leaves output latch untouched
// - direct update, or sync via command/pin
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "qdac_defines.svh"
module qdac_serial_port (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_srst,
   // serial link pins
   input  wire logic        i_frame_sel_n,
   input  wire logic        i_sclk,
   input  wire logic        i_serial_data_in,
   output logic             o_serial_data_out,
   // control pins
   input  wire logic        i_output_clear_pin_n,
   input  wire logic        i_latch_update_pin_n,
   input  wire logic        i_por_select,
   // register port
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic [31:0]      o_reg_rdata,
   // latched output codes, channel a in the low bits
   output logic [63:0]      o_latch_code
);

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   qdac_pin_if pin_bus ();

   qdac_pin_sync #(
      .W    (6),
      .IDLE (`QDAC_PIN_IDLE)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_raw     ({i_por_select, i_latch_update_pin_n, i_output_clear_pin_n,
                   i_serial_data_in, i_sclk, i_frame_sel_n}),
      .pins      (pin_bus.src)
   );

   logic [5:0] lvl;
   logic [5:0] prev_q;
   logic       fs_fall;
   logic       fs_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       clr_fall;
   logic       latch_update_pin_fall;
   logic       por_sel;

   assign lvl = pin_bus.lvl;

   // previous levels for edge finding on the filtered pins
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prev_q <= `QDAC_PIN_IDLE;
      end else begin
         prev_q <= lvl;
      end
   end

   assign fs_fall   = prev_q[`QDAC_PIN_FS]   & ~lvl[`QDAC_PIN_FS];
   assign fs_rise   = ~prev_q[`QDAC_PIN_FS]  & lvl[`QDAC_PIN_FS];
   assign sclk_rise = ~prev_q[`QDAC_PIN_SCLK] & lvl[`QDAC_PIN_SCLK];
   assign sclk_fall = prev_q[`QDAC_PIN_SCLK] & ~lvl[`QDAC_PIN_SCLK];
   assign clr_fall  = prev_q[`QDAC_PIN_CLR]  & ~lvl[`QDAC_PIN_CLR];
   assign latch_update_pin_fall = prev_q[`QDAC_PIN_LATCH_UPDATE_PIN] & ~lvl[`QDAC_PIN_LATCH_UPDATE_PIN];
   assign por_sel   = lvl[`QDAC_PIN_POR];

   // ---------------------------------------------------------------
   // frame receiver
   // ---------------------------------------------------------------
   qdac_pkg::qdac_state_t state_q;
   logic [31:0]           shreg_q;
   logic [5:0]            cnt_q;
   logic                  frame_end;
   logic                  frame_done;
   logic                  frame_short;

   // shift msb first on rising clock while select is low
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_q <= qdac_pkg::ST_IDLE;
         shreg_q <= 32'h0000_0000;
         cnt_q   <= 6'h00;
      end else begin
         unique case (state_q)
            qdac_pkg::ST_IDLE: begin
               if (fs_fall) begin
                  state_q <= qdac_pkg::ST_SHIFT;
                  cnt_q   <= 6'h00;
               end
            end
            qdac_pkg::ST_SHIFT: begin
               if (fs_rise) begin
                  state_q <= qdac_pkg::ST_IDLE;
               end else if (sclk_rise) begin
                  shreg_q <= {shreg_q[30:0], lvl[`QDAC_PIN_SERIAL_DATA_IN]};
                  if (cnt_q != `QDAC_CNT_MAX) begin
                     cnt_q <= cnt_q + 6'h01;
                  end
               end
            end
         endcase
      end
   end

   // acts only on select release after exactly one full frame
   assign frame_end   = (state_q == qdac_pkg::ST_SHIFT) && fs_rise;
   assign frame_done  = frame_end && (cnt_q == `QDAC_FRAME_BITS);
   assign frame_short = frame_end && (cnt_q < `QDAC_FRAME_BITS);

   // device drives out the bit leaving the shift register on falling clock
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_serial_data_out <= 1'b0;
      end else if ((state_q == qdac_pkg::ST_SHIFT) && sclk_fall) begin
         o_serial_data_out <= shreg_q[31];
      end
   end

   // ---------------------------------------------------------------
   // frame decode
   // ---------------------------------------------------------------
   logic [3:0]  f_cmd;
   logic [3:0]  f_ch;
   logic [15:0] f_data;
   logic        f_write;
   logic        f_wr_upd;
   logic [3:0]  ch_hit;

   assign f_cmd    = shreg_q[`QDAC_CMD_HI:`QDAC_CMD_LO];
   assign f_ch     = shreg_q[`QDAC_CH_HI:`QDAC_CH_LO];
   assign f_data   = shreg_q[`QDAC_DATA_HI:`QDAC_DATA_LO];
   assign f_write  = frame_done && ((f_cmd == qdac_pkg::CMD_WRITE) ||
                                    (f_cmd == qdac_pkg::CMD_WRITE_UPD));
   assign f_wr_upd = f_cmd == qdac_pkg::CMD_WRITE_UPD;

   // address nibble, all-ones reaches every channel
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ch_hit[i] = f_write && ((f_ch == 4'(i)) || (f_ch == `QDAC_CH_ALL));
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic                     sync_mode_q;
   qdac_pkg::qdac_clr_mode_t clr_mode_q;
   logic [15:0]              user_code_q;
   logic [7:0]               short_cnt_q;
   logic [2:0]               por_wait_q;
   logic                     por_done_q;
   logic                     por_load;
   logic [15:0]              clr_code;
   logic [15:0]              por_code;

   // software writes; clear mode resets to the zero-volt code
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         sync_mode_q <= 1'b0;
         clr_mode_q  <= qdac_pkg::CLR_ZERO;
         user_code_q <= `QDAC_RST_USER_CODE;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            `QDAC_REG_CTRL:      sync_mode_q <= i_reg_wdata[`QDAC_CTRL_SYNC_BIT];
            `QDAC_REG_CLR_MODE:  clr_mode_q  <= qdac_pkg::qdac_clr_mode_t'(i_reg_wdata[1:0]);
            `QDAC_REG_USER_CODE: user_code_q <= i_reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // count dropped short frames, saturating, for software visibility
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         short_cnt_q <= 8'h00;
      end else if (frame_short && (short_cnt_q != 8'hff)) begin
         short_cnt_q <= short_cnt_q + 8'h01;
      end
   end

   // strap reaches the filtered level four edges after release, so the load waits five
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         por_wait_q <= 3'h0;
         por_done_q <= 1'b0;
      end else if (!por_done_q) begin
         if (por_wait_q == `QDAC_POR_SETTLE) begin
            por_done_q <= 1'b1;
         end else begin
            por_wait_q <= por_wait_q + 3'h1;
         end
      end
   end

   assign por_load = !por_done_q && (por_wait_q == `QDAC_POR_SETTLE);
   assign por_code = por_sel ? `QDAC_CODE_MID : `QDAC_CODE_ZERO;

   // code forced by a clear event
   always_comb begin
      unique case (clr_mode_q)
         qdac_pkg::CLR_ZERO: clr_code = `QDAC_CODE_ZERO;
         qdac_pkg::CLR_MID:  clr_code = `QDAC_CODE_MID;
         qdac_pkg::CLR_FULL: clr_code = `QDAC_CODE_FULL;
         qdac_pkg::CLR_USER: clr_code = user_code_q;
      endcase
   end

   // ---------------------------------------------------------------
   // input buffers and output latches
   // ---------------------------------------------------------------
   logic [3:0][15:0] buf_q;
   logic [3:0][15:0] lat_q;
   logic             upd_all;

   // in sync mode every latch loads on the command or the pin edge
   assign upd_all = sync_mode_q &&
                    (latch_update_pin_fall || (frame_done && (f_cmd == qdac_pkg::CMD_UPDATE)));

   // clear beats frames and updates arriving in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         buf_q <= '0;
         lat_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (por_load) begin
               buf_q[i] <= por_code;
               lat_q[i] <= por_code;
            end else if (clr_fall) begin
               buf_q[i] <= clr_code;
               lat_q[i] <= clr_code;
            end else begin
               if (ch_hit[i]) begin
                  buf_q[i] <= f_data;
               end
               if (upd_all) begin
                  lat_q[i] <= ch_hit[i] ? f_data : buf_q[i];
               end else if (ch_hit[i] && (!sync_mode_q || f_wr_upd)) begin
                  lat_q[i] <= f_data;
               end
            end
         end
      end
   end

   assign o_latch_code = lat_q;

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   // data stand for one cycle only; unmapped addresses read zero
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_reg_rdata <= 32'h0000_0000;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `QDAC_REG_CTRL:      o_reg_rdata <= {31'h0, sync_mode_q};
            `QDAC_REG_CLR_MODE:  o_reg_rdata <= {30'h0, clr_mode_q};
            `QDAC_REG_USER_CODE: o_reg_rdata <= {16'h0, user_code_q};
            `QDAC_REG_STATUS:    o_reg_rdata <= {16'h0, short_cnt_q, 7'h0, por_done_q};
            8'h10:               o_reg_rdata <= {16'h0, lat_q[0]};
            8'h14:               o_reg_rdata <= {16'h0, lat_q[1]};
            8'h18:               o_reg_rdata <= {16'h0, lat_q[2]};
            8'h1c:               o_reg_rdata <= {16'h0, lat_q[3]};
            8'h20:               o_reg_rdata <= {16'h0, buf_q[0]};
            8'h24:               o_reg_rdata <= {16'h0, buf_q[1]};
            8'h28:               o_reg_rdata <= {16'h0, buf_q[2]};
            8'h2c:               o_reg_rdata <= {16'h0, buf_q[3]};
            default:             o_reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_reg_rdata <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);

   logic quiet;
   assign quiet = !por_load && !clr_fall;

   a_sdo_shift_out: assert property (
      (state_q == qdac_pkg::ST_SHIFT) && sclk_fall && !fs_rise
      |=> o_serial_data_out == $past(shreg_q[31]))
      else $error("serial out does not follow shift register msb");

   a_bit_count_step: assert property (
      (state_q == qdac_pkg::ST_SHIFT) && sclk_rise && !fs_rise && (cnt_q < 6'd32)
      |=> (cnt_q == $past(cnt_q) + 6'h01) && (shreg_q[0] == $past(lvl[2])))
      else $error("bit counter or shift did not advance");

   a_data_left_align: assert property (
      f_write && (f_ch == 4'h0) && quiet
      |=> buf_q[0] == $past(shreg_q[19:4]))
      else $error("channel a buffer not loaded from bits 19 to 4");

   a_chan_broadcast: assert property (
      f_write && (f_ch == 4'hf) && quiet
      |=> (buf_q[0] == buf_q[3]) && (buf_q[1] == buf_q[2]) && (buf_q[2] == buf_q[3]))
      else $error("broadcast write did not reach all channels");

   a_por_known_code: assert property (
      por_load |=> por_done_q && (lat_q[0] == buf_q[3]) && (lat_q[2] == lat_q[1]))
      else $error("power-on load did not fill every channel");

   a_por_zero_scale: assert property (
      por_load && !por_sel |=> (lat_q == '0) && (buf_q == '0))
      else $error("grounded select did not give zero scale");

   a_clear_forces: assert property (
      clr_fall && !por_load
      |=> (lat_q[1] == $past(clr_code)) && (buf_q[2] == $past(clr_code)))
      else $error("clear edge did not force clear code");

   a_clear_default: assert property (
      clr_fall && !por_load && (clr_mode_q == qdac_pkg::CLR_ZERO) |=> lat_q == '0)
      else $error("default clear did not reach zero volts");

   a_buffer_isolated: assert property (
      sync_mode_q && f_write && !f_wr_upd && !latch_update_pin_fall && quiet |=> $stable(lat_q))
      else $error("buffer write disturbed the output latch");

   a_sync_pin_update: assert property (
      sync_mode_q && latch_update_pin_fall && !frame_done && quiet |=> lat_q == $past(buf_q))
      else $error("update pin did not copy buffers to latches");

   a_async_direct: assert property (
      !sync_mode_q && f_write && (f_ch == 4'h3) && quiet
      |=> lat_q[3] == $past(f_data))
      else $error("asynchronous write did not reach the latch");

   a_act_on_release: assert property (
      !frame_end && quiet |=> $stable(buf_q))
      else $error("buffer changed outside a frame end");

   a_short_ignored: assert property (
      frame_short && quiet |=> $stable(buf_q) && $stable(lat_q) && $stable(clr_mode_q))
      else $error("short frame changed device state");

   c_full_frame:   cover property (frame_done && f_write);
   c_short_frame:  cover property (frame_short);
   c_clear_user:   cover property (clr_fall && (clr_mode_q == qdac_pkg::CLR_USER));
   c_pin_update:   cover property (sync_mode_q && latch_update_pin_fall);

endmodule : qdac_serial_port

// file: qdac_defines.svh
// constants of the quad dac serial command port
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

// ----------------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------------
`define QDAC_FRAME_BITS     6'd32
`define QDAC_CNT_MAX        6'h3f
`define QDAC_CMD_HI         27
`define QDAC_CMD_LO         24
`define QDAC_CH_HI          23
`define QDAC_CH_LO          20
`define QDAC_DATA_HI        19
`define QDAC_DATA_LO        4
`define QDAC_CH_ALL         4'hf

// ----------------------------------------------------------------------
// synchronised pin positions inside the level vector
// ----------------------------------------------------------------------
`define QDAC_PIN_FS         0
`define QDAC_PIN_SCLK       1
`define QDAC_PIN_SERIAL_DATA_IN       2
`define QDAC_PIN_CLR        3
`define QDAC_PIN_LATCH_UPDATE_PIN       4
`define QDAC_PIN_POR        5
`define QDAC_PIN_IDLE       6'h19

// ----------------------------------------------------------------------
// codes and timing
// ----------------------------------------------------------------------
`define QDAC_CODE_ZERO      16'h0000
`define QDAC_CODE_MID       16'h8000
`define QDAC_CODE_FULL      16'hffff
`define QDAC_POR_SETTLE     3'h5

// ----------------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------------
`define QDAC_REG_CTRL       8'h00
`define QDAC_REG_CLR_MODE   8'h04
`define QDAC_REG_USER_CODE  8'h08
`define QDAC_REG_STATUS     8'h0c
`define QDAC_REG_LATCH0     8'h10
`define QDAC_REG_BUF0       8'h20
`define QDAC_CTRL_SYNC_BIT  0
`define QDAC_RST_USER_CODE  16'h0000

`endif

// file: qdac_pkg.sv
// types shared by the quad dac serial command port
package qdac_pkg;

   // frame receiver states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } qdac_state_t;

   // code forced by a clear event
   typedef enum logic [1:0] {
      CLR_ZERO = 2'h0,
      CLR_MID  = 2'h1,
      CLR_FULL = 2'h2,
      CLR_USER = 2'h3
   } qdac_clr_mode_t;

   // command nibble of a frame
   typedef enum logic [3:0] {
      CMD_WRITE     = 4'h0,
      CMD_WRITE_UPD = 4'h1,
      CMD_UPDATE    = 4'h2
   } qdac_cmd_t;

endpackage : qdac_pkg

// file: qdac_pin_if.sv
// carrier of synchronised pin levels between the synchroniser and the core
`timescale 1ns/1ps
interface qdac_pin_if;
   logic [5:0] lvl;

   modport src (output lvl);
   modport dst (input  lvl);
endinterface : qdac_pin_if

// file: qdac_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module qdac_pin_sync #(
   parameter int         W    = 6,
   parameter logic [5:0] IDLE = 6'h00
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_srst,
   // raw pins
   input  wire logic [W-1:0] i_raw,
   // filtered levels
   qdac_pin_if.src           pins
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] clean_q;

   // ---------------------------------------------------------------
   // synchroniser chain
   // ---------------------------------------------------------------
   // first stage feeds only the second, so metastability never fans out
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s1_q <= IDLE[W-1:0];
         s2_q <= IDLE[W-1:0];
         s3_q <= IDLE[W-1:0];
      end else begin
         s1_q <= i_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit changes only once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         clean_q <= IDLE[W-1:0];
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               clean_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign pins.lvl = clean_q;

endmodule : qdac_pin_sync

// file: qdac_host_model.sv
// host controller model that shifts command frames into the serial port
`timescale 1ns/1ps
module qdac_host_model (
   // clock and request
   input  wire logic        i_clk_sys,
   input  wire logic        i_start,
   input  wire logic [31:0] i_frame,
   input  wire logic [5:0]  i_nbits,
   // serial link pins
   output logic             o_frame_sel_n,
   output logic             o_sclk,
   output logic             o_serial_data_in,
   input  wire logic        i_serial_data_out,
   // status and echo of the outgoing data line
   output logic             o_busy,
   output logic [31:0]      o_echo
);
   // ----------------------------------------------------------------------
   // frame generator
   // ----------------------------------------------------------------------
   initial begin
      o_frame_sel_n    = 1'b1;
      o_sclk           = 1'b0;
      o_serial_data_in = 1'b0;
      o_busy           = 1'b0;
      o_echo           = 32'h0000_0000;
   end

   // sclk runs only inside a frame, off phase with the system clock
   always begin
      @(posedge i_clk_sys);
      if (i_start === 1'b1) begin
         o_busy = 1'b1;
         #13 o_frame_sel_n = 1'b0;
         o_serial_data_in = i_frame[31];
         for (int i = 0; i < i_nbits; i++) begin
            #160 o_sclk = 1'b1;
            #159 o_echo = {o_echo[30:0], i_serial_data_out};
            // data move on the falling clock, so each bit is settled at the rise
            #1 o_sclk = 1'b0;
            if (i < 31) begin
               o_serial_data_in = i_frame[30-i];
            end
         end
         #160 o_frame_sel_n = 1'b1;
         // released data line shows the inverse, not a stale bit
         o_serial_data_in = ~o_serial_data_in;
         #400 o_busy = 1'b0;
      end
   end
endmodule : qdac_host_model

// file: tb_qdac_serial_port.sv
// self-checking bench of the quad dac serial command port
`timescale 1ns/1ps
module tb_qdac_serial_port;
   // ----------------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------------
   typedef struct {logic [31:0] fr; logic [63:0] lat;} qdac_row_t;
   logic        clk = 1'b0, srst = 1'b1, clr_n = 1'b1, upd_n = 1'b1, por_sel = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, start = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wd = 32'h0000_0000, fr = 32'h0000_0000, rdat, echo;
   logic [31:0] rdat_v;
   logic [5:0]  nb = 6'h20;
   logic        fs_n, sclk, serial_data_in, serial_data_out, busy;
   logic [63:0] lat;
   logic [15:0] c;
   qdac_row_t   rows [7];
   int          err_count = 0;
   int          n_tests = 0;

   qdac_serial_port i_qdac_serial_port (.i_clk_sys(clk), .i_srst(srst),
      .i_frame_sel_n(fs_n), .i_sclk(sclk), .i_serial_data_in(serial_data_in),
      .o_serial_data_out(serial_data_out), .i_output_clear_pin_n(clr_n), .i_latch_update_pin_n(upd_n),
      .i_por_select(por_sel), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdat), .o_latch_code(lat));
   qdac_host_model i_qdac_host_model (.i_clk_sys(clk), .i_start(start), .i_frame(fr),
      .i_nbits(nb), .o_frame_sel_n(fs_n), .o_sclk(sclk), .o_serial_data_in(serial_data_in),
      .i_serial_data_out(serial_data_out), .o_busy(busy), .o_echo(echo));

   initial begin
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] mk(input logic [3:0] cm, input logic [3:0] ch,
                                      input logic [15:0] cd);
      mk = {4'h0, cm, ch, cd, 4'h0};
   endfunction : mk

   task automatic final_report;
      if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdat;
   endtask : reg_rd

   // bounded wait for the model, then time for the pin sync to settle
   task automatic send(input logic [31:0] f, input logic [5:0] n);
      int k;
      k = 0;
      @(posedge clk);
      fr <= f; nb <= n; start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (busy !== 1'b0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (k >= 400) begin
         err_count++;
         final_report();
      end
      repeat (8) @(posedge clk);
   endtask : send

   task automatic pulse(input logic sel);
      @(posedge clk);
      if (sel) clr_n <= 1'b0; else upd_n <= 1'b0;
      repeat (4) @(posedge clk);
      clr_n <= 1'b1; upd_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : pulse

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rows[0] = '{mk(4'h1, 4'h0, 16'h1234), 64'h8000_8000_8000_1234};
      rows[1] = '{mk(4'h1, 4'h1, 16'habcd), 64'h8000_8000_abcd_1234};
      rows[2] = '{mk(4'h1, 4'h2, 16'hffff), 64'h8000_ffff_abcd_1234};
      rows[3] = '{mk(4'h1, 4'h3, 16'h0001), 64'h0001_ffff_abcd_1234};
      rows[4] = '{mk(4'h1, 4'hf, 16'h5a5a) | 32'h0000_000f, {4{16'h5a5a}}};
      rows[5] = '{mk(4'h0, 4'h2, 16'h7777), 64'h5a5a_7777_5a5a_5a5a};
      rows[6] = '{mk(4'h1, 4'h0, 16'h00ff) | 32'ha000_0000, 64'h5a5a_7777_5a5a_00ff};
      // strap low, then a second reset with strap high
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      chk(lat, 64'h0);
      srst <= 1'b1;
      por_sel <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      chk(lat, {4{16'h8000}});
      reg_rd(8'h04, rdat_v);
      chk(rdat_v, 64'h0);
      reg_rd(8'h40, rdat_v);
      chk(rdat_v, 64'h0);
      // ordinary frames in asynchronous mode
      for (int r = 0; r < 7; r++) begin
         send(rows[r].fr, 6'd32);
         chk(lat, rows[r].lat);
      end
      chk(echo, rows[5].fr);
      reg_rd(8'h28, rdat_v);
      chk(rdat_v, 64'h7777);
      reg_rd(8'h10, rdat_v);
      chk(rdat_v, 64'h00ff);
      // a frame one bit short changes nothing and is counted
      send(mk(4'h1, 4'h0, 16'h1111), 6'd31);
      chk(lat, rows[6].lat);
      reg_rd(8'h0c, rdat_v);
      chk(rdat_v, 64'h0101);
      // synchronous mode: pin update, then the update command
      reg_wr(8'h00, 32'h1);
      send(mk(4'h0, 4'h0, 16'h2222), 6'd32);
      send(mk(4'h0, 4'h1, 16'h3333), 6'd32);
      chk(lat, rows[6].lat);
      pulse(1'b0);
      chk(lat, 64'h5a5a_7777_3333_2222);
      send(mk(4'h0, 4'h3, 16'h4444), 6'd32);
      send(mk(4'h2, 4'h0, 16'h0000), 6'd32);
      chk(lat, 64'h4444_7777_3333_2222);
      // clear with the default mode, then every mode
      pulse(1'b1);
      chk(lat, 64'h0);
      reg_wr(8'h08, 32'h0abc);
      for (int m = 0; m < 4; m++) begin
         reg_wr(8'h04, m);
         send(mk(4'h1, 4'hf, 16'h1357), 6'd32);
         pulse(1'b1);
         c = (m == 0) ? 16'h0000 : (m == 1) ? 16'h8000 : (m == 2) ? 16'hffff : 16'h0abc;
         chk(lat, {4{c}});
         reg_rd(8'h24, rdat_v);
         chk(rdat_v, {48'h0, c});
      end
      final_report();
   end
endmodule : tb_qdac_serial_port
